// ==== include/fcml_consts.vh ====
`ifndef FCML_CONSTS_VH
`define FCML_CONSTS_VH

// ----------------------------------------
// Mode codes, most significant pin first
// ----------------------------------------
`define FCML_MODE_MSER 3'h0
`define FCML_MODE_RSVD 3'h1
`define FCML_MODE_XBYTE 3'h2
`define FCML_MODE_PSYNC 3'h3
`define FCML_MODE_MPUP 3'h4
`define FCML_MODE_PASYNC 3'h5
`define FCML_MODE_MPDN 3'h6
`define FCML_MODE_SSER 3'h7

// ----------------------------------------
// Bitstream fields
// ----------------------------------------
`define FCML_PREAMBLE 8'hF2
`define FCML_LEN_BITS 5'h18
`define FCML_CHECK_FIELD 4'h6
`define FCML_ADDR_UP_START 18'h00000
`define FCML_ADDR_DN_START 18'h3FFFF

// ----------------------------------------
// Timing
// ----------------------------------------
`define FCML_CLOCK_PERIOD_NS 8
`define FCML_OSC_PERIOD_NS 1000
`define FCML_OSC_DIV ((`FCML_OSC_PERIOD_NS + `FCML_CLOCK_PERIOD_NS - 1) / `FCML_CLOCK_PERIOD_NS)
`define FCML_RELEASE_TICKS 2'h2

`endif

// ==== hdl/fcml_osc_div.v ====
`timescale 1ns/1ns
`default_nettype none

// ----------------------------------------
// Internal oscillator stand-in
// ----------------------------------------
module fcml_osc_div #(
  parameter DIV = 125
) (
  input wire clock,
  input wire rst,
  output reg tick
);

  // Terminal count held at the counter's own width
  localparam [11:0] LAST = DIV - 1;

  reg [11:0] cnt_q;

  // One-cycle enable every DIV clocks, about 1 MHz
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      cnt_q <= 12'h000;
      tick <= 1'b0;
    end else if (cnt_q == LAST) begin
      cnt_q <= 12'h000;
      tick <= 1'b1;
    end else begin
      cnt_q <= cnt_q + 12'h001;
      tick <= 1'b0;
    end
  end

endmodule

`default_nettype wire

// ==== hdl/fcml_loader.v ====
`timescale 1ns/1ns
`default_nettype none
`include "fcml_consts.vh"

module fcml_loader #(
  parameter OSC_DIV = `FCML_OSC_DIV
) (
  input wire clock,
  input wire rst,
  input wire mode_select_bit0,
  input wire mode_select_bit1,
  input wire mode_select_bit2,
  input wire init_high,
  input wire config_shift_clock_in,
  output reg config_shift_clock_out,
  output reg config_shift_clock_oe_n,
  input wire serial_data_in,
  input wire [7:0] config_byte_bus,
  input wire chain_select_in,
  input wire host_write_strobe,
  output reg ready_busy,
  output reg [17:0] prom_addr,
  output reg serial_data_out,
  output reg config_bit,
  output reg config_bit_valid,
  output reg [7:0] config_byte,
  output reg config_byte_valid,
  input wire config_mem_full,
  input wire frame_end_strobe,
  output reg crc_enable,
  output reg check_error,
  output reg [23:0] length_count,
  output reg config_released,
  output reg mode_reserved
);

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  localparam HUNT = 3'h1;
  localparam LEN = 3'h2;
  localparam DATA = 3'h4;

  reg [15:0] pin_meta_q;
  reg [15:0] pin_q;
  wire [15:0] pins;
  assign pins = {host_write_strobe, chain_select_in, config_byte_bus, serial_data_in,
                 config_shift_clock_in, init_high, mode_select_bit2, mode_select_bit1,
                 mode_select_bit0};

  // Two stages for every pin; only pin_q is looked at
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      pin_meta_q <= 16'h0000;
      pin_q <= 16'h0000;
    end else begin
      pin_meta_q <= pins;
      pin_q <= pin_meta_q;
    end
  end

  wire [2:0] mode_pins = pin_q[2:0];
  wire init_s = pin_q[3];
  wire xclk_s = pin_q[4];
  wire din_s = pin_q[5];
  wire [7:0] bus_s = pin_q[13:6];
  wire cs_s = pin_q[14];
  wire wr_s = pin_q[15];

  // ----------------------------------------
  // Oscillator and release timing
  // ----------------------------------------
  wire osc_tick;
  fcml_osc_div #(.DIV(OSC_DIV)) u_osc (
    .clock(clock),
    .rst(rst),
    .tick(osc_tick)
  );

  reg [1:0] rel_cnt_q;
  reg [2:0] mode_q;
  reg xclk_d1_q;
  reg wr_d1_q;

  // Release two oscillator ticks after init seen high; mode caught then
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      rel_cnt_q <= 2'h0;
      config_released <= 1'b0;
      mode_q <= `FCML_MODE_SSER;
      mode_reserved <= 1'b0;
    end else if (!init_s) begin
      rel_cnt_q <= 2'h0;
      config_released <= 1'b0;
    end else if (!config_released && osc_tick) begin
      if (rel_cnt_q == `FCML_RELEASE_TICKS - 2'h1) begin
        config_released <= 1'b1;
        mode_q <= mode_pins;
        mode_reserved <= (mode_pins == `FCML_MODE_RSVD);
      end
      rel_cnt_q <= rel_cnt_q + 2'h1;
    end
  end

  // Decoded mode flags; reserved code selects nothing
  wire m_mser = mode_q == `FCML_MODE_MSER;
  wire m_sser = mode_q == `FCML_MODE_SSER;
  wire m_mpup = mode_q == `FCML_MODE_MPUP;
  wire m_mpdn = mode_q == `FCML_MODE_MPDN;
  wire m_psync = mode_q == `FCML_MODE_PSYNC;
  wire m_pasync = mode_q == `FCML_MODE_PASYNC;
  wire m_xbyte = mode_q == `FCML_MODE_XBYTE;
  wire m_mpar = m_mpup | m_mpdn;
  wire clk_is_out = m_mser | m_mpar | m_pasync;
  wire run = config_released;

  // ----------------------------------------
  // Shift clock generation and edges
  // ----------------------------------------
  reg [3:0] bits_left_q;
  reg [7:0] shift_q;

  // Master modes run free; async peripheral only while a byte is left
  wire gen_en = run & ((m_mser | m_mpar) | (m_pasync & (bits_left_q != 4'h0)));
  wire gen_rise = osc_tick & gen_en & ~config_shift_clock_out;
  wire gen_fall = osc_tick & config_shift_clock_out;
  wire x_rise = xclk_s & ~xclk_d1_q;
  wire x_fall = ~xclk_s & xclk_d1_q;
  wire rise = clk_is_out ? gen_rise : x_rise;
  wire fall = clk_is_out ? gen_fall : x_fall;
  wire wr_rise = wr_s & ~wr_d1_q;

  always @(posedge clock or posedge rst) begin
    if (rst) begin
      config_shift_clock_out <= 1'b0;
      config_shift_clock_oe_n <= 1'b1;
      xclk_d1_q <= 1'b0;
      wr_d1_q <= 1'b0;
    end else begin
      xclk_d1_q <= xclk_s;
      wr_d1_q <= wr_s;
      config_shift_clock_oe_n <= ~(run & clk_is_out);
      if (gen_rise) begin
        config_shift_clock_out <= 1'b1;
      end else if (gen_fall) begin
        config_shift_clock_out <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // Bit and byte events
  // ----------------------------------------
  wire ser_mode = m_mser | m_sser;
  wire shift_mode = m_mpar | m_pasync | m_psync;
  wire load_now = m_mpar & (bits_left_q == 4'h0);
  wire bit_ev = run & rise & (ser_mode | (shift_mode & (bits_left_q != 4'h0)) | load_now);
  wire bit_val = ser_mode ? din_s : (load_now ? bus_s[7] : shift_q[7]);
  wire byte_ev = run & m_xbyte & x_rise;

  // Byte path: PROM fetch, host write, serializer
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      bits_left_q <= 4'h0;
      shift_q <= 8'h00;
      prom_addr <= `FCML_ADDR_UP_START;
      ready_busy <= 1'b0;
    end else if (!run) begin
      bits_left_q <= 4'h0;
      // Start address follows the pins so it is ready at release
      if (init_s && mode_pins == `FCML_MODE_MPDN) begin
        prom_addr <= `FCML_ADDR_DN_START;
      end else begin
        prom_addr <= `FCML_ADDR_UP_START;
      end
      ready_busy <= 1'b0;
    end else begin
      if (bit_ev && load_now) begin
        shift_q <= {bus_s[6:0], 1'b0};
        bits_left_q <= 4'h7;
        prom_addr <= m_mpdn ? prom_addr - 18'h00001 : prom_addr + 18'h00001;
      end else if (bit_ev && shift_mode) begin
        shift_q <= {shift_q[6:0], 1'b0};
        bits_left_q <= bits_left_q - 4'h1;
      end else if ((m_pasync || m_psync) && wr_rise && bits_left_q == 4'h0) begin
        shift_q <= bus_s;
        bits_left_q <= 4'h8;
      end
      // Ready only while no byte is being shifted
      ready_busy <= (m_pasync | m_psync) & (bits_left_q == 4'h0) & ~wr_rise;
    end
  end

  // ----------------------------------------
  // Header tracking and storage
  // ----------------------------------------
  reg [2:0] hdr_q;
  reg [4:0] len_left_q;
  reg [6:0] hist_q;
  reg last_bit_q;
  reg chain_q;
  wire [7:0] win = {hist_q, bit_val};
  wire in_data = hdr_q == DATA;
  wire store_ok = in_data & ~config_mem_full;

  always @(posedge clock or posedge rst) begin
    if (rst) begin
      hdr_q <= HUNT;
      len_left_q <= 5'h00;
      hist_q <= 7'h00;
      length_count <= 24'h000000;
    end else if (!run) begin
      hdr_q <= HUNT;
      hist_q <= 7'h00;
    end else if (bit_ev || byte_ev) begin
      hist_q <= win[6:0];
      case (hdr_q)
        HUNT: begin
          if ((byte_ev && bus_s == `FCML_PREAMBLE) || (bit_ev && win == `FCML_PREAMBLE)) begin
            hdr_q <= LEN;
            len_left_q <= `FCML_LEN_BITS;
          end
        end
        LEN: begin
          // Bytes count eight bits of the length at a time
          if (byte_ev) begin
            length_count <= {length_count[15:0], bus_s};
            len_left_q <= len_left_q - 5'h08;
            if (len_left_q == 5'h08) begin
              hdr_q <= DATA;
            end
          end else begin
            length_count <= {length_count[22:0], bit_val};
            len_left_q <= len_left_q - 5'h01;
            if (len_left_q == 5'h01) begin
              hdr_q <= DATA;
            end
          end
        end
        DATA: begin
          hdr_q <= DATA;
        end
        default: begin
          hdr_q <= HUNT;
        end
      endcase
    end
  end

  // Store to configuration memory; byte path needs select and room
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      config_bit <= 1'b0;
      config_bit_valid <= 1'b0;
      config_byte <= 8'h00;
      config_byte_valid <= 1'b0;
      last_bit_q <= 1'b1;
    end else begin
      config_bit_valid <= bit_ev & store_ok;
      config_byte_valid <= byte_ev & store_ok & cs_s;
      if (bit_ev) begin
        config_bit <= bit_val;
        last_bit_q <= bit_val;
      end
      if (byte_ev && store_ok && cs_s) begin
        config_byte <= bus_s;
      end
    end
  end

  // ----------------------------------------
  // Downstream output and checks
  // ----------------------------------------
  // Chain status goes low at release, high once memory is full
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      chain_q <= 1'b1;
    end else if (!run) begin
      chain_q <= 1'b1;
    end else begin
      chain_q <= config_mem_full;
    end
  end

  // Header passes through, then high until loaded, then data forwarded
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      serial_data_out <= 1'b1;
    end else if (m_xbyte || !run) begin
      serial_data_out <= run ? chain_q : 1'b1;
    end else if (fall) begin
      serial_data_out <= (!in_data || config_mem_full) ? last_bit_q : 1'b1;
    end
  end

  // Constant check replaces CRC in byte slave; sticky until init drops
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      crc_enable <= 1'b0;
      check_error <= 1'b0;
    end else if (!run) begin
      crc_enable <= 1'b0;
      check_error <= 1'b0;
    end else begin
      crc_enable <= ~m_xbyte & ~mode_reserved;
      if (m_xbyte && frame_end_strobe && config_byte[3:0] != `FCML_CHECK_FIELD) begin
        check_error <= 1'b1;
      end
    end
  end

endmodule

`default_nettype wire

// ==== tb/fcml_loader_chk.sv ====
`timescale 1ns/1ns
`default_nettype none
// ----
// Port checker
// ----
module fcml_loader_chk #(
  parameter int OSC_DIV = 4
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic mode_select_bit0,
  input wire logic mode_select_bit1,
  input wire logic mode_select_bit2,
  input wire logic init_high,
  input wire logic chain_select_in,
  input wire logic config_mem_full,
  input wire logic config_shift_clock_oe_n,
  input wire logic ready_busy,
  input wire logic serial_data_out,
  input wire logic config_byte_valid,
  input wire logic config_released,
  input wire logic mode_reserved
);
  wire logic [2:0] mode_pins = {mode_select_bit2, mode_select_bit1, mode_select_bit0};
  // Single domain, so one clock and reset for all
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (rst);
  // Mode pins only change while init is low, so mode-pin terms are safe
  chk_oe_slave: assert property (
    config_released && mode_pins inside {3'h7, 3'h3, 3'h2} |-> config_shift_clock_oe_n)
    else $error("shift clock driven in external clock mode");
  chk_valid_one: assert property (
    config_byte_valid |=> !config_byte_valid) else $error("byte valid too long");
  chk_byte_sel: assert property (
    config_byte_valid |-> chain_select_in && !config_mem_full) else $error("refused byte stored");
  chk_init_low: assert property (
    !init_high [*4] |-> !config_released) else $error("released while init low");
  chk_rel_wait: assert property (
    $rose(config_released) |-> $past(init_high, OSC_DIV)) else $error("released too early");
  chk_ready_mode: assert property (
    ready_busy |-> mode_pins inside {3'h3, 3'h5}) else $error("ready outside peripheral mode");
  chk_rsv_quiet: assert property (
    mode_reserved |-> config_shift_clock_oe_n && !config_byte_valid)
    else $error("activity in reserved mode");
  chk_chain_status: assert property (
    config_released && $past(config_released, 3) && init_high && mode_pins == 3'h2
    && config_mem_full == $past(config_mem_full, 3) |-> serial_data_out == config_mem_full)
    else $error("chain status wrong");
endmodule
`default_nettype wire

// ==== tb/fcml_byte_src.sv ====
`timescale 1ns/1ns
`default_nettype none
// ----
// External byte source
// ----
module fcml_byte_src (
  output var logic config_shift_clock,
  output var logic [7:0] data
);
  // Clock rests low between bytes
  initial begin
    config_shift_clock = 1'h0;
    data = 8'h00;
  end
  // One 125 ns cycle per byte; old data is not left on the bus
  task automatic send(input logic [7:0] b);
    data = b;
    #63 config_shift_clock = 1'h1;
    #62 config_shift_clock = 1'h0;
    data = ~b;
  endtask
endmodule
`default_nettype wire

// ==== tb/test_fpga_config_mode_loader.sv ====
`timescale 1ns/1ns
`default_nettype none
// ----
// Loader bench
// ----
module test_fpga_config_mode_loader;
  localparam int DIV = 4;
  logic clock = 1'h0;
  logic rst = 1'h1;
  logic init_high = 1'h0;
  logic sdi = 1'h0;
  logic csel = 1'h1;
  logic hws = 1'h0;
  logic full = 1'h0;
  logic fend = 1'h0;
  logic [2:0] mode = 3'h2;
  logic [23:0] lenv;
  logic [7:0] b;
  logic [7:0] got[$];
  logic [7:0] exp_q[$];
  wire config_shift_clock, cko, oe_n, rdy, sdo, cbv, crc, cerr, rel, rsv;
  wire [7:0] bus;
  wire [7:0] cbyte;
  wire [17:0] addr;
  wire [23:0] len;
  wire config_shift_clock_pin = oe_n ? config_shift_clock : cko;
  int n_errors = 0;
  int n_checks = 0;
  int rises;
  // Clock, serial noise and byte capture
  always #4 clock = ~clock;
  always @(posedge clock) sdi <= #1 1'($urandom);
  always @(posedge clock) if (cbv === 1'h1) got.push_back(cbyte);
  fcml_loader #(.OSC_DIV(DIV)) u_fcml_loader (
    .clock(clock), .rst(rst), .mode_select_bit0(mode[0]), .mode_select_bit1(mode[1]),
    .mode_select_bit2(mode[2]), .init_high(init_high), .config_shift_clock_in(config_shift_clock_pin),
    .config_shift_clock_out(cko), .config_shift_clock_oe_n(oe_n), .serial_data_in(sdi),
    .config_byte_bus(bus), .chain_select_in(csel), .host_write_strobe(hws),
    .ready_busy(rdy), .prom_addr(addr), .serial_data_out(sdo), .config_bit(),
    .config_bit_valid(), .config_byte(cbyte), .config_byte_valid(cbv),
    .config_mem_full(full), .frame_end_strobe(fend), .crc_enable(crc),
    .check_error(cerr), .length_count(len), .config_released(rel), .mode_reserved(rsv));
  fcml_byte_src u_fcml_byte_src (.config_shift_clock(config_shift_clock), .data(bus));
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] expv);
    n_checks++;
    if (seen !== expv) begin
      n_errors++;
      $display("[FAIL] %s expected %0h seen %0h", what, expv, seen);
    end
  endtask
  task automatic end_sim();
    if (n_errors == 0 && n_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  // Mode pins only move while init is low
  task automatic restart(input logic [2:0] m);
    init_high = 1'h0;
    cyc(8);
    mode = m;
    init_high = 1'h1;
    for (int i = 0; i < 60 && rel !== 1'h1; i++) cyc(1);
    chk("released", rel, 1'h1);
  endtask
  function automatic logic [17:0] exp_addr(input int m);
    return m == 4 ? 18'h00003 : 18'h3FFFC;
  endfunction
  // Cut a hang short; the tests need well under 20000 cycles
  initial begin
    #400000;
    n_errors++;
    end_sim();
  end
  // Mode sweep, then byte slave frames
  initial begin
    void'($urandom(32'h8766));
    cyc(12);
    rst = 1'h0;
    cyc(2);
    chk("idle_status", sdo, 1'h1);
    for (int m = 0; m < 8; m++) begin
      restart(m[2:0]);
      cyc(2);
      chk("clk_oe", oe_n, !(m inside {0, 4, 5, 6}));
      chk("ready", rdy, m inside {3, 5});
      chk("crc", crc, !(m inside {1, 2}));
      chk("reserved", rsv, m == 1);
      if (m == 4 || m == 6) begin
        for (int i = 0; i < 600 && addr !== exp_addr(m); i++) cyc(1);
        chk("prom_addr", addr, exp_addr(m));
      end
      if (m == 5) begin
        hws = 1'h1;
        for (int i = 0; i < 10 && rdy !== 1'h0; i++) cyc(1);
        chk("busy", rdy, 1'h0);
        rises = 0;
        for (int i = 0; i < 300 && rdy !== 1'h1; i++) begin
          b[0] = cko;
          cyc(1);
          rises += int'(cko === 1'h1 && b[0] === 1'h0);
        end
        chk("burst", rises, 8);
        hws = 1'h0;
      end
    end
    for (int p = 0; p < 2; p++) begin
      full = 1'h0;
      restart(3'h2);
      cyc(625); // Source waits before its first edge
      chk("status_low", sdo, 1'h0);
      got.delete();
      exp_q.delete();
      lenv = 24'($urandom);
      u_fcml_byte_src.send(8'hFF);
      u_fcml_byte_src.send(8'hF2);
      for (int i = 2; i >= 0; i--) u_fcml_byte_src.send(lenv[i*8 +: 8]);
      for (int i = 0; i < 4; i++) begin
        b = 8'($urandom);
        if (i == 3) b[3:0] = p ? 4'h9 : 4'h6;
        exp_q.push_back(b);
        u_fcml_byte_src.send(b);
      end
      cyc(6);
      chk("length", len, lenv);
      csel = 1'h0;
      u_fcml_byte_src.send(8'($urandom));
      cyc(6);
      csel = 1'h1; // Lead device select held high
      full = 1'h1;
      cyc(4);
      chk("status_full", sdo, 1'h1);
      u_fcml_byte_src.send(8'($urandom));
      cyc(6);
      chk("stored", got.size(), exp_q.size());
      foreach (exp_q[i]) chk("byte", got[i], exp_q[i]);
      fend = 1'h1;
      cyc(1);
      fend = 1'h0;
      cyc(4);
      chk("check_err", cerr, p[0]);
    end
    end_sim();
  end
endmodule
bind fcml_loader fcml_loader_chk #(.OSC_DIV(OSC_DIV)) u_fcml_loader_chk (
  .clock(clock), .rst(rst), .mode_select_bit0(mode_select_bit0),
  .mode_select_bit1(mode_select_bit1), .mode_select_bit2(mode_select_bit2),
  .init_high(init_high), .chain_select_in(chain_select_in), .config_mem_full(config_mem_full),
  .config_shift_clock_oe_n(config_shift_clock_oe_n), .ready_busy(ready_busy),
  .serial_data_out(serial_data_out), .config_byte_valid(config_byte_valid),
  .config_released(config_released), .mode_reserved(mode_reserved));
`default_nettype wire
